// >>> design/adc_seq_map.svh
/*
 * register bit positions, reset values and timing counts for the
 * converter sequencer. assumes a 25 MHz ref_clk.
 */
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define CTRL_WRITE_BIT      15
`define CTRL_REPEAT_BIT     14
`define CTRL_CH_HI          13
`define CTRL_CH_LO          6
`define CTRL_TEMP_BIT       4
`define CTRL_EXTREF_BIT     2
`define CTRL_AVG_BIT        1
`define CTRL_PPD_BIT        0
`define CTRL_RESET_VALUE    16'h0000
`define FRAME_BITS          16
`define TRACK_EDGE          14
`define TAG_TEMP            4'h8
`define TAG_TEMP_AVG        4'h9
`define ALL_ONES_WORD       16'hFFFF
`define CLK_PERIOD_NS       40
`define PDRST_LONG_NS       100
`define PDRST_LONG_CYCLES   ((`PDRST_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> design/adc_seq_pkg.sv
/*
 * shared types for the converter sequencer.
 * assumes adc_seq_map.svh supplies the numeric constants.
 */
package adc_seq_pkg;
    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_PARTIAL,
        PWR_FULL
    } power_state_e;
    typedef logic [15:0] word_t;
endpackage

// >>> design/adc_sequencer_power_control.sv
/*
 * control logic of an eight-input serial converter with a temperature
 * channel: serial frame decode, sequencing, latency, power-down.
 * assumes sclk, cs_n, din and the power-down/reset pin are asynchronous
 * pins sampled by ref_clk; analog results arrive as a parallel word.
 *
// Overview of operation
// - traditional mode, repeat zero; first frame configures, its output invalid.
// - result of a conversion shifts out in the next frame.
// - without repeat, selected channels convert ascending, then stop until rewrite.
// - output all ones when sequence done or nothing selected.
// - repeat cycles selected channels ascending, wrapping to lowest.
// - temperature converts after the last selected analog channel.
// - any write during repeat restarts at the lowest selected channel.
// - clearing repeat in a write returns to traditional sequencing.
// - conversion starts at frame start; tracking resumes at 14th falling edge.
// - first 16 bits load control register only if write-enable set.
// - full write with partial power-down set enters it at frame end.
// - in partial power-down every frame shifts out all ones.
// - averaging state clears on entering partial or full power-down.
// - clearing power-down bit wakes at frame end; then configure.
// - after wake the first valid result comes in the fourth frame.
// - pin low over 100 ns gives full power-down, cleared registers.
// - reset clears control register to zero.
// - short low pulse on pin resets all registers.
// - each output word is a 4-bit channel tag then 12-bit result.
// - control word: write, repeat, channels, temp, external_reference_select, avg, ppd.
// - frame ending before 16 clocks aborts, tristates, keeps register.
 */
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module adc_sequencer_power_control
    import adc_seq_pkg::*;
#(
    parameter int PDRST_CYCLES = `PDRST_LONG_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic        power_down_reset_pin,
    input  wire logic [11:0] adc_result,
    output logic             dout,
    output logic             dout_oe,
    output logic             track_hold,
    output logic             convert_start,
    output logic [3:0]       mux_channel,
    output logic             external_reference_select,
    output logic             temperature_averaging_enable,
    output logic             avg_clear,
    output logic             partial_power_down,
    output logic             full_power_down
);
    // pin synchronisers
    logic [1:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] din_sync_reg;
    logic [1:0] pin_sync_reg;
    logic       sclk_d_reg;
    logic       cs_d_reg;

    // reset to idle levels, clock and select high, so no false edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_reg <= 2'b11;
            cs_sync_reg   <= 2'b11;
            din_sync_reg  <= 2'b00;
            pin_sync_reg  <= 2'b11;
            sclk_d_reg    <= 1'b1;
            cs_d_reg      <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk};
            cs_sync_reg   <= {cs_sync_reg[0], cs_n};
            din_sync_reg  <= {din_sync_reg[0], din};
            pin_sync_reg  <= {pin_sync_reg[0], power_down_reset_pin};
            sclk_d_reg    <= sclk_sync_reg[1];
            cs_d_reg      <= cs_sync_reg[1];
        end
    end

    // edge detection on the second stage only
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic pin_low;
    assign cs_fall   = cs_d_reg && !cs_sync_reg[1];
    assign cs_rise   = !cs_d_reg && cs_sync_reg[1];
    assign sclk_fall = sclk_d_reg && !sclk_sync_reg[1] && !cs_sync_reg[1];
    assign pin_low   = !pin_sync_reg[1];

    // power-down/reset pin width qualification
    logic [7:0] pin_cnt_reg;
    logic       soft_reset;
    logic       pin_long;
    // long once the count passes the threshold
    assign pin_long = (pin_cnt_reg >= 8'(PDRST_CYCLES + 1));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_cnt_reg <= 8'h00;
        end else if (!pin_low) begin
            pin_cnt_reg <= 8'h00;
        end else if (!pin_long) begin
            pin_cnt_reg <= pin_cnt_reg + 8'h01;
        end
    end
    // any low pulse clears the registers, short or long
    assign soft_reset = pin_low;

    // serial frame: shift in control word, count falling edges
    logic [15:0] shift_in_reg;
    logic [4:0]  fall_cnt_reg;
    logic        full_frame;
    assign full_frame = (fall_cnt_reg >= 5'(`FRAME_BITS));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_in_reg <= 16'h0000;
            fall_cnt_reg <= 5'h00;
        end else if (cs_fall || soft_reset) begin
            shift_in_reg <= 16'h0000;
            fall_cnt_reg <= 5'h00;
        end else if (sclk_fall && !full_frame) begin
            // bits taken only during the first 16 clocks
            shift_in_reg <= {shift_in_reg[14:0], din_sync_reg[1]};
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
        end
    end

    // control register and power state
    logic [15:0]  ctrl_reg;
    power_state_e pwr_reg;
    logic         frame_done;
    logic         do_write;
    assign frame_done = cs_rise && full_frame;
    assign do_write   = frame_done && shift_in_reg[`CTRL_WRITE_BIT];

    // control register: zero at reset, kept on aborted frames
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET_VALUE;
        end else if (soft_reset) begin
            ctrl_reg <= `CTRL_RESET_VALUE;
        end else if (do_write) begin
            ctrl_reg <= shift_in_reg;
        end
    end

    // power state follows the bit at frame end, pin overrides
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= PWR_NORMAL;
        end else if (pin_long) begin
            pwr_reg <= PWR_FULL;
        end else if (soft_reset) begin
            pwr_reg <= PWR_NORMAL;
        end else if (pwr_reg == PWR_FULL) begin
            pwr_reg <= PWR_NORMAL;
        end else if (do_write) begin
            // enter or leave partial power-down at frame end
            pwr_reg <= shift_in_reg[`CTRL_PPD_BIT] ? PWR_PARTIAL
                                                    : PWR_NORMAL;
        end
    end

    // sequencer: next slot to convert, armed by writes
    logic [8:0] sel;
    logic       pick_found;
    logic [3:0] pick_slot;
    logic       wrap_found;
    logic [3:0] wrap_slot;
    logic [3:0] next_slot_reg;
    logic       seq_live_reg;
    // temperature sits in slot 8, after every analog input
    assign sel = {ctrl_reg[`CTRL_TEMP_BIT],
                  ctrl_reg[`CTRL_CH_LO], ctrl_reg[`CTRL_CH_LO+1],
                  ctrl_reg[`CTRL_CH_LO+2], ctrl_reg[`CTRL_CH_LO+3],
                  ctrl_reg[`CTRL_CH_LO+4], ctrl_reg[`CTRL_CH_LO+5],
                  ctrl_reg[`CTRL_CH_LO+6], ctrl_reg[`CTRL_CH_HI]};

    // lowest pending slot, and lowest overall for the wrap
    seq_pick #(
        .SLOTS (9)
    ) u_pick (
        .sel   (sel),
        .start (next_slot_reg),
        .found (pick_found),
        .slot  (pick_slot)
    );

    seq_pick #(
        .SLOTS (9)
    ) u_wrap (
        .sel   (sel),
        .start (4'h0),
        .found (wrap_found),
        .slot  (wrap_slot)
    );

    // a slot converts only while fully powered and armed by a write
    logic conv_valid;
    logic normal_now;
    assign normal_now = (pwr_reg == PWR_NORMAL);
    assign conv_valid = seq_live_reg && pick_found && normal_now;

    // advance one slot per frame start; wrap only under repeat
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            next_slot_reg <= 4'h0;
            seq_live_reg  <= 1'b0;
        end else if (soft_reset) begin
            next_slot_reg <= 4'h0;
            seq_live_reg  <= 1'b0;
        end else if (do_write) begin
            next_slot_reg <= 4'h0; // restart at lowest
            seq_live_reg  <= 1'b1;
        end else if (cs_fall && conv_valid) begin
            if (ctrl_reg[`CTRL_REPEAT_BIT]) begin
                next_slot_reg <= pick_slot + 4'h1;
            end else begin
                next_slot_reg <= pick_slot + 4'h1;
            end
        end else if (cs_fall && !pick_found && ctrl_reg[`CTRL_REPEAT_BIT]
                     && wrap_found && normal_now && seq_live_reg) begin
            next_slot_reg <= wrap_slot + 4'h1; // wrap, convert lowest
        end
    end

    // which slot converts this frame, including the repeat wrap
    logic       conv_now;
    logic [3:0] conv_slot;
    assign conv_now  = conv_valid ||
                       (seq_live_reg && normal_now && !pick_found &&
                        ctrl_reg[`CTRL_REPEAT_BIT] && wrap_found);
    assign conv_slot = pick_found ? pick_slot : wrap_slot;

    // frame-level conversion state and one-frame result latency
    logic        cur_valid_reg;
    logic [3:0]  cur_tag_reg;
    logic        conv_done_reg;
    logic [15:0] out_word_reg;
    logic [15:0] shift_out_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_valid_reg <= 1'b0;
            cur_tag_reg   <= 4'h0;
            conv_done_reg <= 1'b0;
            out_word_reg  <= `ALL_ONES_WORD;
        end else if (soft_reset) begin
            cur_valid_reg <= 1'b0;
            cur_tag_reg   <= 4'h0;
            conv_done_reg <= 1'b0;
            out_word_reg  <= `ALL_ONES_WORD;
        end else if (cs_fall) begin
            // start this frame's conversion
            cur_valid_reg <= conv_now;
            cur_tag_reg   <= conv_slot;
            conv_done_reg <= 1'b0;
        end else if (frame_done && cur_valid_reg) begin
            // publish for the next frame, tag then data
            conv_done_reg <= 1'b1;
            out_word_reg  <= {tag_of(cur_tag_reg), adc_result};
        end else if (frame_done || cs_rise) begin
            // nothing converted or aborted frame
            out_word_reg  <= `ALL_ONES_WORD;
        end
    end

    // channel tag: slot number, or the temperature code
    function automatic logic [3:0] tag_of(input logic [3:0] slot);
        if (slot == 4'h8) begin
            tag_of = ctrl_reg[`CTRL_AVG_BIT] ? `TAG_TEMP_AVG : `TAG_TEMP;
        end else begin
            tag_of = slot;
        end
    endfunction

    // output shifter: first bit on cs fall, next on each falling edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_out_reg <= `ALL_ONES_WORD;
            dout          <= 1'b1;
            dout_oe       <= 1'b0;
        end else if (cs_fall) begin
            // partial power-down or first frame gives all ones
            shift_out_reg <= normal_now ? out_word_reg : `ALL_ONES_WORD;
            dout          <= normal_now ? out_word_reg[15] : 1'b1;
            dout_oe       <= 1'b1;
        end else if (cs_rise || soft_reset) begin
            dout_oe       <= 1'b0;
        end else if (sclk_fall) begin
            if (fall_cnt_reg == 5'(`FRAME_BITS - 1)) begin
                dout_oe <= 1'b0;
            end
            shift_out_reg <= {shift_out_reg[14:0], 1'b1};
            dout          <= shift_out_reg[14];
        end
    end

    // track/hold, conversion strobe and mux
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            track_hold    <= 1'b1;
            convert_start <= 1'b0;
            mux_channel   <= 4'h0;
        end else begin
            convert_start <= cs_fall && conv_now && !soft_reset;
            if (cs_fall) begin
                track_hold  <= 1'b0; // hold at frame start
                mux_channel <= conv_slot;
            end else if (sclk_fall &&
                         fall_cnt_reg == 5'(`TRACK_EDGE - 1)) begin
                track_hold  <= 1'b1; // back to track
            end else if (cs_rise) begin
                track_hold  <= 1'b1;
            end
        end
    end

    // configuration outputs and averaging clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            external_reference_select    <= 1'b0;
            temperature_averaging_enable <= 1'b0;
            avg_clear                    <= 1'b0;
            partial_power_down           <= 1'b0;
            full_power_down              <= 1'b0;
        end else begin
            external_reference_select    <= ctrl_reg[`CTRL_EXTREF_BIT];
            temperature_averaging_enable <= ctrl_reg[`CTRL_AVG_BIT];
            partial_power_down           <= (pwr_reg == PWR_PARTIAL);
            full_power_down              <= (pwr_reg == PWR_FULL);
            // one pulse on entry to either power-down
            avg_clear <= (do_write && shift_in_reg[`CTRL_PPD_BIT] &&
                          pwr_reg != PWR_PARTIAL) ||
                         (pin_long && pwr_reg != PWR_FULL);
        end
    end
endmodule // adc_sequencer_power_control

// >>> design/seq_pick.sv
/*
 * next-channel picker: lowest selected slot at or above a start slot.
 * slots 0..7 are inputs, slot 8 the temperature channel.
 * assumes a purely combinational use by the sequencer.
 */
`timescale 1ns/1ps
module seq_pick #(
    parameter int SLOTS = 9
) (
    input  wire logic [SLOTS-1:0] sel,
    input  wire logic [3:0]       start,
    output logic                  found,
    output logic [3:0]            slot
);
    // scan downward so the lowest eligible slot wins
    always_comb begin
        found = 1'b0;
        slot  = 4'h0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (sel[i] && (4'(i) >= start)) begin
                found = 1'b1;
                slot  = 4'(i);
            end
        end
    end
endmodule // seq_pick

// >>> verif/adc_host_model.sv
/*
 * host side of the serial link: frames transfers with chip select and
 * a 320 ns serial clock that idles high between frames.
 * assumes the bench calls xfer only after reset has been released.
 */
`timescale 1ns/1ps
module adc_host_model
    import adc_seq_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic dout,
    input  wire logic dout_oe,
    output logic      sclk,
    output logic      cs_n,
    output logic      din
);
    // idle link levels
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one framed transfer of n falling edges, word msb first
    task automatic xfer(input word_t w, input int n, output word_t r);
        r = 16'hFFFF;
        @(posedge ref_clk);
        #2;
        cs_n = 1'b0; // frame start
        for (int i = 0; i < n; i++) begin
            din = w[15-i]; // control bits msb first
            #160;
            r[15-i] = dout_oe ? dout : 1'b1; // pulled-up line
            sclk = 1'b0;
            #160;
            sclk = 1'b1;
        end
        din = ~din; // released line shows no stale level
        #160;
        cs_n = 1'b1;
        #400; // quiet interval, rate well under the limit
    endtask
endmodule // adc_host_model

// >>> verif/adc_seq_monitor.sv
/*
 * concurrent checks on the sequencer's pins: frame start, output
 * release, power-down levels and clear pulses.
 * assumes it is bound to the sequencer top and sees only its ports.
 */
`timescale 1ns/1ps
module adc_seq_monitor #(
    parameter int PDRST_CYCLES = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic power_down_reset_pin,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic track_hold,
    input wire logic convert_start,
    input wire logic external_reference_select,
    input wire logic temperature_averaging_enable,
    input wire logic avg_clear,
    input wire logic partial_power_down,
    input wire logic full_power_down
);
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // consecutive cycles with the pin seen low
    logic [7:0] low_cnt;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || power_down_reset_pin) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end

    // conversion start, hold and output release
    a_start_hold: assert property (convert_start |-> !track_hold)
        else $error("hold not taken at conversion start");
    a_start_pulse: assert property (convert_start |=> !convert_start)
        else $error("conversion start longer than one cycle");
    a_start_cs: assert property (convert_start |-> !$past(cs_n))
        else $error("conversion start outside a frame");
    a_oe_release: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
        else $error("output still driven after frame end");
    // power-down levels and clear pulses
    a_ppd_ones: assert property (partial_power_down && dout_oe |-> dout)
        else $error("zero bit shifted out in partial power-down");
    a_full_clear: assert property (full_power_down |->
        !external_reference_select && !partial_power_down
        && !temperature_averaging_enable)
        else $error("settings kept in full power-down");
    a_long_low: assert property (low_cnt == 8'(PDRST_CYCLES + 4)
        |-> ##[0:3] full_power_down)
        else $error("long low pin gave no full power-down");
    a_avg_enter: assert property ($rose(partial_power_down)
        |-> $past(avg_clear))
        else $error("no average clear on partial power-down");
    a_avg_pulse: assert property (avg_clear |=> !avg_clear)
        else $error("average clear longer than one cycle");
endmodule // adc_seq_monitor

bind adc_sequencer_power_control adc_seq_monitor #(
    .PDRST_CYCLES(PDRST_CYCLES)
) mon_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
    .power_down_reset_pin(power_down_reset_pin), .dout(dout),
    .dout_oe(dout_oe), .track_hold(track_hold),
    .convert_start(convert_start),
    .external_reference_select(external_reference_select),
    .temperature_averaging_enable(temperature_averaging_enable),
    .avg_clear(avg_clear), .partial_power_down(partial_power_down),
    .full_power_down(full_power_down)
);

// >>> verif/tb_adc_sequencer_power_control.sv
/*
 * self-checking bench for the converter sequencer: each scenario task
 * runs frames through the host model and judges words and levels.
 * assumes the host model and the bound monitor are compiled with it.
 */
`timescale 1ns/1ps
module tb_adc_sequencer_power_control
    import adc_seq_pkg::*;
();
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        power_down_reset_pin = 1'b1;
    logic [11:0] adc_result = 12'h5A3;
    logic [11:0] prev_res = 12'h000;
    wire         sclk, cs_n, din, dout, dout_oe, track_hold, convert_start;
    wire  [3:0]  mux_channel;
    wire         external_reference_select, temperature_averaging_enable;
    wire         avg_clear, partial_power_down, full_power_down;
    word_t       got;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          avg_cnt = 0;

    // 25 MHz reference clock
    always #20 ref_clk = ~ref_clk;

    adc_sequencer_power_control dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .power_down_reset_pin(power_down_reset_pin),
        .adc_result(adc_result), .dout(dout), .dout_oe(dout_oe),
        .track_hold(track_hold), .convert_start(convert_start),
        .mux_channel(mux_channel),
        .external_reference_select(external_reference_select),
        .temperature_averaging_enable(temperature_averaging_enable),
        .avg_clear(avg_clear), .partial_power_down(partial_power_down),
        .full_power_down(full_power_down)
    );
    adc_host_model host_u (
        .ref_clk(ref_clk), .dout(dout), .dout_oe(dout_oe),
        .sclk(sclk), .cs_n(cs_n), .din(din)
    );

    // cycle ceiling and count of average clear pulses
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (avg_clear === 1'b1)
            avg_cnt <= avg_cnt + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input word_t seen, input word_t exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    // one frame; tag 5'h10 expects all ones, 5'h1F and mux 4'hF skip
    task automatic step(input word_t w, input logic [4:0] tag,
                        input logic [3:0] mux);
        tick(1);
        prev_res = adc_result;
        adc_result = adc_result + 12'h111;
        host_u.xfer(w, 16, got);
        if (tag != 5'h1F)
            check(got, tag[4] ? 16'hFFFF : {tag[3:0], prev_res});
        if (mux != 4'hF)
            check({12'h000, mux_channel}, {12'h000, mux});
    endtask

    task automatic t_defaults();
        chk1(partial_power_down, 1'b0);
        chk1(full_power_down, 1'b0);
        chk1(external_reference_select, 1'b0);
        chk1(temperature_averaging_enable, 1'b0);
        chk1(dout_oe, 1'b0);
        step(16'h0000, 5'h10, 4'hF);
    endtask

    task automatic t_traditional();
        step(16'hA800, 5'h1F, 4'hF);
        step(16'h0000, 5'h10, 4'h0);
        step(16'h0000, 5'h00, 4'h2);
        step(16'h0000, 5'h02, 4'hF);
        step(16'h0000, 5'h10, 4'hF);
    endtask

    task automatic t_repeat();
        step(16'hD050, 5'h1F, 4'hF);
        step(16'h0000, 5'h10, 4'h1);
        step(16'h0000, 5'h01, 4'h7);
        step(16'h0000, 5'h07, 4'h8);
        step(16'h0000, 5'h08, 4'h1);
        step(16'hD050, 5'h1F, 4'hF);
        step(16'h0000, 5'h07, 4'h1);
        step(16'h9000, 5'h1F, 4'hF);
        step(16'h0000, 5'h1F, 4'h1);
        step(16'h0000, 5'h01, 4'hF);
        step(16'h0000, 5'h10, 4'hF);
    endtask

    task automatic t_abort();
        tick(1);
        host_u.xfer(16'h8004, 8, got);
        chk1(dout_oe, 1'b0);
        chk1(external_reference_select, 1'b0);
        step(16'h8004, 5'h1F, 4'hF);
        chk1(external_reference_select, 1'b1);
    endtask

    task automatic t_partial();
        int a;
        a = avg_cnt;
        step(16'h8400, 5'h1F, 4'hF);
        step(16'h8013, 5'h10, 4'h3);
        chk1(partial_power_down, 1'b1);
        chk1(temperature_averaging_enable, 1'b1);
        check(16'(avg_cnt - a), 16'h0001);
        step(16'h0000, 5'h10, 4'hF);
        step(16'h8000, 5'h10, 4'hF);
        chk1(partial_power_down, 1'b0);
        step(16'h8400, 5'h1F, 4'hF);
        step(16'h0000, 5'h10, 4'h3);
        step(16'h0000, 5'h03, 4'hF);
    endtask

    task automatic t_pin();
        step(16'h8004, 5'h1F, 4'hF);
        power_down_reset_pin = 1'b0;
        tick(1);
        power_down_reset_pin = 1'b1;
        tick(4);
        chk1(external_reference_select, 1'b0);
        chk1(full_power_down, 1'b0);
        step(16'h8004, 5'h1F, 4'hF);
        power_down_reset_pin = 1'b0;
        tick(12);
        chk1(full_power_down, 1'b1);
        power_down_reset_pin = 1'b1;
        tick(6);
        chk1(full_power_down, 1'b0);
        chk1(external_reference_select, 1'b0);
        tick(10); // wake-up wait before programming
        step(16'h8004, 5'h1F, 4'hF);
        chk1(external_reference_select, 1'b1);
    endtask

    // reset, then the scenarios in order
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(4); // interface usable before first write
        t_defaults();
        t_traditional();
        t_repeat();
        t_abort();
        t_partial();
        t_pin();
        end_sim();
    end
endmodule // tb_adc_sequencer_power_control
